/* File: rtl/spi_ee_pkg.sv */
// Function
// - Chip select rising ends the operation or launches the internal write.
// - Deselected and idle: device in standby, serial output not driven.
// - Input bits sampled on SCK rising, output bits shifted on SCK falling.
// - Protect pin low with protect-enable set freezes guard bits and enable.
// - Suspend input low pauses the sequence; release resumes without restart.
// - Status writes refused under hardware protection or with latch clear.
// - Bit 0 shows busy; while busy only read status is accepted.
// - Bit 1 is the write latch; set by set command, cleared at reset.
// - Bits 2 and 3 are guard bits, zero from factory, select protection.
// - Bits 4 to 6 are not kept and read zero outside write cycles.
// - Bit 7 is protect-enable; it locks status but never the array.
// - Protect-enable cannot go from 1 to 0 while protect pin is low.
// - During an internal write cycle every status bit reads 1.
// - Guard 00 none, 01 upper quarter, 10 upper half, 11 whole array.
// - Eight opcode bits shifted in, then address, data in or data out.
// - All fields travel most significant bit first.
// - Opcodes: set latch X110, clear latch X100, read status X101.
// - Opcodes: write status X001, array read X011, array write X010.
// - Clear latch, accepted status write and array write end with latch cleared; a status write refused under protection leaves it set.
// - Array write stays in one 32-byte page, wraps, keeps last 32 bytes.
// - Array read streams sequential bytes, wraps at the end to zero.
// - Only address bits 9 to 0 select a byte; upper bits ignored.
package spi_ee_pkg;
   localparam int ADDR_W = 10;
   localparam int DEPTH = 1024;
   localparam int PAGE_W = 5;
   localparam int PAGE_BYTES = 32;
   localparam int PAGE_BITS = 256;
   localparam logic [3:0] OPC_UPPER = 4'h0;
   localparam logic [2:0] OPC_SET = 3'h6;
   localparam logic [2:0] OPC_CLR = 3'h4;
   localparam logic [2:0] OPC_RDST = 3'h5;
   localparam logic [2:0] OPC_WRST = 3'h1;
   localparam logic [2:0] OPC_RDA = 3'h3;
   localparam logic [2:0] OPC_WRA = 3'h2;
   localparam int SB_NRDY = 0;
   localparam int SB_WEL = 1;
   localparam int SB_BG0 = 2;
   localparam int SB_BG1 = 3;
   localparam int SB_HWPE = 7;
   localparam logic [7:0] STAT_BUSY = 8'hFF;
   localparam logic [ADDR_W-1:0] PROT_QUARTER = 10'h300;
   localparam logic [ADDR_W-1:0] PROT_HALF = 10'h200;
   localparam logic [1:0] BG_NONE = 2'h0;
   localparam logic [1:0] BG_QUARTER = 2'h1;
   localparam logic [1:0] BG_HALF = 2'h2;
   localparam int BUSY_W = 20;
   localparam longint WRITE_TIME_NS = 5000000;
   localparam longint CLK_PERIOD_NS = 10;
   localparam logic [BUSY_W-1:0] WRITE_CYCLES_DFLT =
      BUSY_W'(WRITE_TIME_NS / CLK_PERIOD_NS);

   typedef enum logic [2:0] {
      PH_IDLE = 3'h0,
      PH_OPCODE = 3'h1,
      PH_ADDR = 3'h3,
      PH_DIN = 3'h2,
      PH_DOUT = 3'h6,
      PH_IGNORE = 3'h7
   } phase_t;

   typedef enum logic [2:0] {
      CMD_NONE = 3'h0,
      CMD_SET = 3'h1,
      CMD_CLR = 3'h2,
      CMD_RDST = 3'h3,
      CMD_WRST = 3'h4,
      CMD_RDA = 3'h5,
      CMD_WRA = 3'h6
   } cmd_t;

   function automatic cmd_t decode_op(input logic [7:0] op);
      cmd_t c;
      c = CMD_NONE;
      if (op[7:4] == OPC_UPPER) begin
         unique case (op[2:0])
            OPC_SET: c = CMD_SET;
            OPC_CLR: c = CMD_CLR;
            OPC_RDST: c = CMD_RDST;
            OPC_WRST: c = CMD_WRST;
            OPC_RDA: c = CMD_RDA;
            OPC_WRA: c = CMD_WRA;
            default: c = CMD_NONE;
         endcase
      end
      return c;
   endfunction : decode_op

   function automatic logic is_guarded(input logic [1:0] bg,
                                       input logic [ADDR_W-1:0] a);
      logic g;
      g = 1'b1;
      unique case (bg)
         BG_NONE: g = 1'b0;
         BG_QUARTER: g = (a >= PROT_QUARTER);
         BG_HALF: g = (a >= PROT_HALF);
         default: g = 1'b1;
      endcase
      return g;
   endfunction : is_guarded

   function automatic logic [7:0] status_view(input logic busy,
                                              input logic hwpe,
                                              input logic [1:0] bg,
                                              input logic wel);
      logic [7:0] v;
      v = 8'h00;
      v[SB_HWPE] = hwpe;
      v[SB_BG1] = bg[1];
      v[SB_BG0] = bg[0];
      v[SB_WEL] = wel;
      v[SB_NRDY] = busy;
      if (busy) begin
         v = STAT_BUSY;
      end
      return v;
   endfunction : status_view
endpackage : spi_ee_pkg

/* File: rtl/ee_mem_if.sv */
`timescale 1ns/100ps
`default_nettype none
interface ee_mem_if;
   logic wr_en;
   logic [9:0] wr_addr;
   logic [7:0] wr_data;
   logic rd_en;
   logic [9:0] rd_addr;
   logic [7:0] rd_data;
   modport ctrl(output wr_en, output wr_addr, output wr_data,
                output rd_en, output rd_addr, input rd_data);
   modport mem(input wr_en, input wr_addr, input wr_data,
               input rd_en, input rd_addr, output rd_data);
endinterface : ee_mem_if
`default_nettype wire

/* File: rtl/ee_array.sv */
`timescale 1ns/100ps
`default_nettype none
module ee_array (
   input wire logic sys_clk_i,
   input wire logic sys_rst_i,
   ee_mem_if.mem bus
);
   logic [7:0] cell_q [spi_ee_pkg::DEPTH];
   logic [7:0] rd_q;

   always_ff @(posedge sys_clk_i) begin
      if (bus.wr_en) begin
         cell_q[bus.wr_addr] <= bus.wr_data;
      end
   end

   always_ff @(posedge sys_clk_i) begin
      if (sys_rst_i) begin
         rd_q <= 8'h00;
      end else if (bus.rd_en) begin
         rd_q <= cell_q[bus.rd_addr];
      end
   end

   assign bus.rd_data = rd_q;
endmodule : ee_array
`default_nettype wire

/* File: rtl/spi_eeprom_command_protect.sv */
`timescale 1ns/100ps
`default_nettype none
module spi_eeprom_command_protect #(
   parameter logic [19:0] WRITE_CYCLES = spi_ee_pkg::WRITE_CYCLES_DFLT
) (
   input wire logic sys_clk_i,
   input wire logic sys_rst_i,
   input wire logic cs_n_i,
   input wire logic sck_i,
   input wire logic si_i,
   input wire logic wp_n_i,
   input wire logic hold_n_i,
   output logic so_o,
   output logic so_oe_o
);
   typedef struct packed {
      logic cs_m;
      logic cs_s;
      logic cs_p;
      logic sck_m;
      logic sck_s;
      logic sck_p;
      logic si_m;
      logic si_s;
      logic wp_m;
      logic wp_s;
      logic hold_m;
      logic hold_s;
      spi_ee_pkg::phase_t phase;
      spi_ee_pkg::cmd_t op;
      spi_ee_pkg::cmd_t pend;
      logic [3:0] cnt;
      logic [7:0] sr;
      logic [spi_ee_pkg::ADDR_W-1:0] addr;
      logic [7:0] stat_data;
      logic stat_pend;
      logic wen;
      logic [1:0] bg;
      logic hwpe;
      logic busy;
      logic [spi_ee_pkg::BUSY_W-1:0] bcnt;
      logic copy_on;
      logic [spi_ee_pkg::PAGE_W-1:0] copy_idx;
      logic [spi_ee_pkg::PAGE_BITS-1:0] page;
      logic [spi_ee_pkg::PAGE_BYTES-1:0] mask;
      logic rd_stat;
      logic drv;
      logic [2:0] tx;
      logic [7:0] osr;
      logic so;
      logic so_oe;
      logic wr_en;
      logic [9:0] wr_addr;
      logic [7:0] wr_data;
      logic rd_en;
      logic [9:0] rd_addr;
   } state_t;

   state_t q;
   state_t d;
   ee_mem_if mem_bus();

   logic sck_rise;
   logic sck_fall;
   logic cs_fall;
   logic cs_rise;
   logic hwp;
   logic [7:0] op_byte;
   spi_ee_pkg::cmd_t op_cmd;
   logic [7:0] in_byte;
   logic [9:0] addr_next;

   // Edges only count while selected and not suspended
   assign sck_rise = q.sck_s & ~q.sck_p & ~q.cs_s & q.hold_s;
   assign sck_fall = ~q.sck_s & q.sck_p & ~q.cs_s & q.hold_s;
   assign cs_fall = ~q.cs_s & q.cs_p;
   assign cs_rise = q.cs_s & ~q.cs_p;
   assign hwp = ~q.wp_s & q.hwpe;
   assign op_byte = {q.sr[6:0], q.si_s};
   assign in_byte = op_byte;
   assign op_cmd = spi_ee_pkg::decode_op(op_byte);
   assign addr_next = {q.addr[8:0], q.si_s};

   always_comb begin
      d = q;
      d.wr_en = 1'b0;
      d.rd_en = 1'b0;
      d.cs_m = cs_n_i;
      d.cs_s = q.cs_m;
      d.cs_p = q.cs_s;
      d.sck_m = sck_i;
      d.sck_s = q.sck_m;
      d.sck_p = q.sck_s;
      d.si_m = si_i;
      d.si_s = q.si_m;
      d.wp_m = wp_n_i;
      d.wp_s = q.wp_m;
      d.hold_m = hold_n_i;
      d.hold_s = q.hold_m;

      // Internal write cycle: page copy first, status update at the end
      if (q.busy) begin
         if (q.copy_on) begin
            if (q.mask[q.copy_idx] &&
                !spi_ee_pkg::is_guarded(q.bg,
                                        {q.addr[9:5], q.copy_idx})) begin
               d.wr_en = 1'b1;
               d.wr_addr = {q.addr[9:5], q.copy_idx};
               d.wr_data = q.page[{q.copy_idx, 3'h0} +: 8];
            end
            d.copy_idx = q.copy_idx + 5'h01;
            if (q.copy_idx == 5'h1F) begin
               d.copy_on = 1'b0;
            end
         end
         if (q.bcnt == WRITE_CYCLES - 20'h00001) begin
            d.busy = 1'b0;
            d.bcnt = 20'h00000;
            if (q.stat_pend && !hwp) begin
               d.bg = {q.stat_data[spi_ee_pkg::SB_BG1],
                       q.stat_data[spi_ee_pkg::SB_BG0]};
               d.hwpe = q.stat_data[spi_ee_pkg::SB_HWPE];
            end
            d.stat_pend = 1'b0;
         end else begin
            d.bcnt = q.bcnt + 20'h00001;
         end
      end

      if (q.cs_s) begin
         d.phase = spi_ee_pkg::PH_IDLE;
         d.drv = 1'b0;
      end

      if (cs_fall) begin
         d.phase = spi_ee_pkg::PH_OPCODE;
         d.cnt = 4'h0;
         d.pend = spi_ee_pkg::CMD_NONE;
         d.tx = 3'h0;
         d.drv = 1'b0;
      end

      // Deselect launches whatever the frame completed
      if (cs_rise) begin
         d.pend = spi_ee_pkg::CMD_NONE;
         unique case (q.pend)
            spi_ee_pkg::CMD_SET: d.wen = 1'b1;
            spi_ee_pkg::CMD_CLR: d.wen = 1'b0;
            spi_ee_pkg::CMD_WRST: begin
               if (q.wen && !hwp) begin
                  d.stat_pend = 1'b1;
                  d.busy = 1'b1;
                  d.bcnt = 20'h00000;
                  d.wen = 1'b0;
               end
            end
            spi_ee_pkg::CMD_WRA: begin
               if (q.wen) begin
                  d.busy = 1'b1;
                  d.bcnt = 20'h00000;
                  d.copy_on = 1'b1;
                  d.copy_idx = 5'h00;
                  d.wen = 1'b0;
               end
            end
            default: d.pend = spi_ee_pkg::CMD_NONE;
         endcase
      end

      if (sck_rise) begin
         d.sr = op_byte;
         d.cnt = q.cnt + 4'h1;
         unique case (q.phase)
            spi_ee_pkg::PH_OPCODE: begin
               if (q.cnt == 4'h7) begin
                  d.cnt = 4'h0;
                  d.op = op_cmd;
                  d.phase = spi_ee_pkg::PH_IGNORE;
                  if (q.busy && op_cmd != spi_ee_pkg::CMD_RDST) begin
                     d.phase = spi_ee_pkg::PH_IGNORE;
                  end else begin
                     unique case (op_cmd)
                        spi_ee_pkg::CMD_SET,
                        spi_ee_pkg::CMD_CLR: d.pend = op_cmd;
                        spi_ee_pkg::CMD_RDST: begin
                           d.phase = spi_ee_pkg::PH_DOUT;
                           d.rd_stat = 1'b1;
                        end
                        spi_ee_pkg::CMD_WRST:
                           d.phase = spi_ee_pkg::PH_DIN;
                        spi_ee_pkg::CMD_RDA,
                        spi_ee_pkg::CMD_WRA:
                           d.phase = spi_ee_pkg::PH_ADDR;
                        default: d.pend = spi_ee_pkg::CMD_NONE;
                     endcase
                  end
               end
            end
            spi_ee_pkg::PH_ADDR: begin
               d.addr = addr_next;
               if (q.cnt == 4'hF) begin
                  d.cnt = 4'h0;
                  if (q.op == spi_ee_pkg::CMD_RDA) begin
                     d.phase = spi_ee_pkg::PH_DOUT;
                     d.rd_stat = 1'b0;
                     d.rd_en = 1'b1;
                     d.rd_addr = addr_next;
                  end else begin
                     d.phase = spi_ee_pkg::PH_DIN;
                     d.mask = 32'h00000000;
                  end
               end
            end
            spi_ee_pkg::PH_DIN: begin
               d.pend = spi_ee_pkg::CMD_NONE;
               if (q.cnt == 4'h7) begin
                  d.cnt = 4'h0;
                  if (q.op == spi_ee_pkg::CMD_WRST) begin
                     d.stat_data = in_byte;
                     d.pend = spi_ee_pkg::CMD_WRST;
                     d.phase = spi_ee_pkg::PH_IGNORE;
                  end else begin
                     // Later bytes overwrite earlier ones in the page
                     d.page[{q.addr[4:0], 3'h0} +: 8] = in_byte;
                     d.mask[q.addr[4:0]] = 1'b1;
                     d.addr[4:0] = q.addr[4:0] + 5'h01;
                     d.pend = spi_ee_pkg::CMD_WRA;
                  end
               end
            end
            spi_ee_pkg::PH_IGNORE: d.pend = spi_ee_pkg::CMD_NONE;
            default: d.cnt = q.cnt;
         endcase
      end

      if (sck_fall && q.phase == spi_ee_pkg::PH_DOUT) begin
         d.tx = q.tx + 3'h1;
         if (q.tx == 3'h0) begin
            if (q.rd_stat) begin
               d.osr = spi_ee_pkg::status_view(q.busy, q.hwpe, q.bg,
                                               q.wen);
            end else begin
               d.osr = mem_bus.rd_data;
               d.addr = q.addr + 10'h001;
               d.rd_en = 1'b1;
               d.rd_addr = q.addr + 10'h001;
            end
            d.drv = 1'b1;
         end
         d.so = d.osr[7];
         d.osr = {d.osr[6:0], 1'b0};
      end

      d.so_oe = d.drv & q.hold_s & ~q.cs_s;

      // Pin pipelines park at idle levels, so no false edge follows reset
      if (sys_rst_i) begin
         d = '0;
         d.cs_m = 1'b1;
         d.cs_s = 1'b1;
         d.cs_p = 1'b1;
         d.wp_m = 1'b1;
         d.wp_s = 1'b1;
         d.hold_m = 1'b1;
         d.hold_s = 1'b1;
      end
   end

   always_ff @(posedge sys_clk_i) begin
      q <= d;
   end

   assign mem_bus.wr_en = q.wr_en;
   assign mem_bus.wr_addr = q.wr_addr;
   assign mem_bus.wr_data = q.wr_data;
   assign mem_bus.rd_en = q.rd_en;
   assign mem_bus.rd_addr = q.rd_addr;
   assign so_o = q.so;
   assign so_oe_o = q.so_oe;

   ee_array u_array (
      .sys_clk_i(sys_clk_i),
      .sys_rst_i(sys_rst_i),
      .bus(mem_bus.mem)
   );

   default clocking cb @(posedge sys_clk_i);
   endclocking
   default disable iff (sys_rst_i);

   a_standby_so_off: assert property (
      q.cs_s && !q.busy |=> !so_oe_o)
      else $error("output driven while deselected");

   a_hold_so_off: assert property (
      !q.hold_s |=> !so_oe_o)
      else $error("output driven while suspended");

   a_busy_rejects_op: assert property (
      sck_rise && q.phase == spi_ee_pkg::PH_OPCODE && q.cnt == 4'h7 &&
      q.busy && op_cmd != spi_ee_pkg::CMD_RDST
      |=> q.phase == spi_ee_pkg::PH_IGNORE && q.pend == spi_ee_pkg::CMD_NONE)
      else $error("opcode accepted while busy");

   a_set_latch_sets: assert property (
      cs_rise && q.pend == spi_ee_pkg::CMD_SET |=> q.wen)
      else $error("latch not set");

   a_clear_latch_clears: assert property (
      cs_rise && q.pend == spi_ee_pkg::CMD_CLR |=> !q.wen ##1 !q.wen)
      else $error("latch not cleared");

   a_guard_frozen: assert property (
      hwp |=> $stable(q.bg) && $stable(q.hwpe))
      else $error("guard bits changed under protection");

   a_array_guarded: assert property (
      mem_bus.wr_en |-> !spi_ee_pkg::is_guarded(q.bg, mem_bus.wr_addr))
      else $error("guarded byte written");

   a_write_in_cycle: assert property (
      $rose(q.copy_on) |-> q.busy && $past(cs_rise))
      else $error("page copy outside write cycle");

   a_busy_reads_ones: assert property (
      q.busy && sck_fall && q.phase == spi_ee_pkg::PH_DOUT && q.rd_stat
      |=> so_o)
      else $error("status bit not 1 while busy");

   a_latch_gates_write: assert property (
      cs_rise && !q.wen && !q.busy |=> !q.busy)
      else $error("write cycle without latch");
endmodule : spi_eeprom_command_protect
`default_nettype wire

/* File: testbench/spi_host_model.sv */
`timescale 1ns/100ps
`default_nettype none
module spi_host_model (
   input wire logic so_i,
   output logic cs_n_o,
   output logic sck_o,
   output logic si_o,
   output logic hold_n_o
);
   logic cpol_q;
   initial begin
      cpol_q = 1'b0;
      cs_n_o = 1'b1;
      sck_o = 1'b0;
      si_o = 1'b0;
      hold_n_o = 1'b1;
   end
   task automatic start(input logic mode3);
      cpol_q = mode3;
      sck_o <= mode3;
      #200;
      cs_n_o <= 1'b0;
      #200;
   endtask : start
   task automatic stop();
      sck_o <= cpol_q;
      #100;
      cs_n_o <= 1'b1;
      si_o <= ~si_o;
      #300;
   endtask : stop
   // Fake clocks while suspended must be ignored by the device
   task automatic pause();
      hold_n_o <= 1'b0;
      #100;
      repeat (3) begin
         sck_o <= 1'b1;
         si_o <= ~si_o;
         #62.5;
         sck_o <= 1'b0;
         #62.5;
      end
      hold_n_o <= 1'b1;
      #100;
   endtask : pause
   task automatic xfer(input logic [7:0] tx, input logic hold,
                       output logic [7:0] rx);
      for (int i = 7; i >= 0; i--) begin
         sck_o <= 1'b0;
         si_o <= tx[i];
         #62.5;
         if (hold && i == 4) begin
            pause();
            si_o <= tx[i];
            #62.5;
         end
         sck_o <= 1'b1;
         rx[i] = so_i;
         #62.5;
      end
   endtask : xfer
endmodule : spi_host_model
`default_nettype wire

/* File: testbench/spi_eeprom_command_protect_tb.sv */
`timescale 1ns/100ps
`default_nettype none
module spi_eeprom_command_protect_tb;
   localparam logic [19:0] WCYC = 20'h001F4;
   logic sys_clk;
   logic sys_rst;
   logic wp_n;
   logic so;
   logic so_oe;
   wire logic cs_n;
   wire logic sck;
   wire logic si;
   wire logic hold_n;
   wire logic so_line;
   int errors = 0;
   int samples_checked = 0;
   logic [7:0] rq[$];
   assign so_line = so_oe ? so : 1'bz;
   spi_host_model u_spi_host_model (
      .so_i(so_line), .cs_n_o(cs_n), .sck_o(sck), .si_o(si),
      .hold_n_o(hold_n));
   spi_eeprom_command_protect #(.WRITE_CYCLES(WCYC))
   u_spi_eeprom_command_protect (
      .sys_clk_i(sys_clk), .sys_rst_i(sys_rst), .cs_n_i(cs_n),
      .sck_i(sck), .si_i(si), .wp_n_i(wp_n), .hold_n_i(hold_n),
      .so_o(so), .so_oe_o(so_oe));
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      samples_checked++;
      if (got !== exp) begin
         errors++;
         $display("wrong value at %0t: got %h expected %h", $time, got,
                  exp);
      end
   endtask : chk
   task automatic frame(input logic [7:0] tx[$], input logic m3,
                        input logic hold);
      logic [7:0] b;
      rq = {};
      u_spi_host_model.start(m3);
      foreach (tx[i]) begin
         u_spi_host_model.xfer(tx[i], hold && i == 1, b);
         rq.push_back(b);
      end
      u_spi_host_model.stop();
   endtask : frame
   task automatic rdst(input logic m3, input logic hold,
                       input logic [7:0] exp);
      frame({8'h05, 8'h00}, m3, hold);
      chk(rq[1], exp);
   endtask : rdst
   task automatic wait_ready();
      int k;
      k = 0;
      do begin
         frame({8'h05, 8'h00}, 1'b0, 1'b0);
         k++;
      end while (rq[1][0] !== 1'b0 && k < 20);
      chk(rq[1] & 8'h01, 8'h00);
   endtask : wait_ready
   task automatic wrst(input logic [7:0] d);
      frame({8'h06}, 1'b0, 1'b0);
      frame({8'h01, d}, 1'b0, 1'b0);
   endtask : wrst
   task automatic wr_arr(input logic [15:0] a, input logic [7:0] q[$]);
      frame({8'h06}, 1'b0, 1'b0);
      frame({8'h02, a[15:8], a[7:0], q}, 1'b0, 1'b0);
      wait_ready();
   endtask : wr_arr
   task automatic rd_arr(input logic [15:0] a, input logic m3);
      frame({8'h03, a[15:8], a[7:0], 8'h00, 8'h00}, m3, 1'b0);
   endtask : rd_arr
   task automatic t_reset();
      @(negedge sys_clk);
      chk({7'h00, so_oe}, 8'h00);
      rdst(1'b0, 1'b0, 8'h00);
      $display("test reset done");
   endtask : t_reset
   task automatic t_latch();
      frame({8'h06}, 1'b0, 1'b0);
      rdst(1'b0, 1'b0, 8'h02);
      frame({8'h04}, 1'b0, 1'b0);
      rdst(1'b1, 1'b0, 8'h00);
      frame({8'h0E}, 1'b0, 1'b0);
      rdst(1'b0, 1'b1, 8'h02);
      frame({8'h0C}, 1'b0, 1'b0);
      rdst(1'b0, 1'b0, 8'h00);
      $display("test latch done");
   endtask : t_latch
   task automatic t_status();
      frame({8'h01, 8'h8C}, 1'b0, 1'b0);
      rdst(1'b0, 1'b0, 8'h00);
      wrst(8'hFC);
      rdst(1'b0, 1'b0, 8'hFF);
      wait_ready();
      rdst(1'b0, 1'b0, 8'h8C);
      $display("test status done");
   endtask : t_status
   task automatic t_protect();
      @(posedge sys_clk);
      wp_n <= 1'b0;
      frame({8'h06}, 1'b0, 1'b0);
      frame({8'h01, 8'h00}, 1'b0, 1'b0);
      rdst(1'b0, 1'b0, 8'h8E);
      @(posedge sys_clk);
      wp_n <= 1'b1;
      wrst(8'h00);
      wait_ready();
      rdst(1'b0, 1'b0, 8'h00);
      $display("test protect done");
   endtask : t_protect
   task automatic t_array();
      wr_arr(16'h041E, {8'hA1, 8'hA2, 8'hA3});
      rd_arr(16'hFC1E, 1'b0);
      chk(rq[3], 8'hA1);
      chk(rq[4], 8'hA2);
      rd_arr(16'h0000, 1'b1);
      chk(rq[3], 8'hA3);
      wr_arr(16'h03FF, {8'h5A});
      rd_arr(16'h03FF, 1'b1);
      chk(rq[3], 8'h5A);
      chk(rq[4], 8'hA3);
      rdst(1'b0, 1'b0, 8'h00);
      $display("test array done");
   endtask : t_array
   task automatic t_guard();
      wr_arr(16'h0300, {8'h11});
      wr_arr(16'h0200, {8'h44});
      wrst(8'h04);
      wait_ready();
      wr_arr(16'h0300, {8'h22});
      wr_arr(16'h02FF, {8'h33});
      rd_arr(16'h02FF, 1'b0);
      chk(rq[3], 8'h33);
      chk(rq[4], 8'h11);
      wrst(8'h08);
      wait_ready();
      wr_arr(16'h0200, {8'h55});
      rd_arr(16'h0200, 1'b0);
      chk(rq[3], 8'h44);
      wrst(8'h00);
      wait_ready();
      $display("test guard done");
   endtask : t_guard
   task automatic t_busy();
      frame({8'h06}, 1'b0, 1'b0);
      frame({8'h02, 8'h00, 8'h10, 8'h77}, 1'b0, 1'b0);
      frame({8'h06}, 1'b0, 1'b0);
      wait_ready();
      rdst(1'b0, 1'b0, 8'h00);
      rd_arr(16'h0010, 1'b0);
      chk(rq[3], 8'h77);
      $display("test busy done");
   endtask : t_busy
   task automatic t_unknown();
      frame({8'hF6, 8'h00}, 1'b0, 1'b0);
      chk(rq[1], 8'hZZ);
      frame({8'h07, 8'h00}, 1'b0, 1'b0);
      chk(rq[1], 8'hZZ);
      rdst(1'b0, 1'b0, 8'h00);
      $display("test unknown done");
   endtask : t_unknown
   task automatic t_rerun();
      frame({8'h06}, 1'b0, 1'b0);
      @(posedge sys_clk);
      sys_rst <= 1'b1;
      repeat (8) @(posedge sys_clk);
      sys_rst <= 1'b0;
      repeat (6) @(posedge sys_clk);
      @(negedge sys_clk);
      chk({7'h00, so_oe}, 8'h00);
      rdst(1'b0, 1'b0, 8'h00);
      $display("test rerun done");
   endtask : t_rerun
   task automatic close_out();
      $display("checks %0d errors %0d", samples_checked, errors);
      if (errors == 0 && samples_checked > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask : close_out
   initial begin
      sys_clk = 1'b0;
      forever #5 sys_clk = ~sys_clk;
   end
   initial begin
      #900000;
      errors++;
      close_out();
   end
   initial begin
      sys_rst = 1'b1;
      wp_n = 1'b1;
      repeat (8) @(posedge sys_clk);
      sys_rst <= 1'b0;
      repeat (6) @(posedge sys_clk);
      t_reset();
      t_latch();
      t_status();
      t_protect();
      t_array();
      t_guard();
      t_busy();
      t_unknown();
      t_rerun();
      close_out();
   end
endmodule : spi_eeprom_command_protect_tb
`default_nettype wire
